//--- src/cmc_pkg.sv
// Purpose: constants for the charger mode control register pair
// Assumes: byte-wide registers behind the serial management bus engine
// Notes:   bit positions, offsets, reset values and timing counts
package cmc_pkg;

	localparam logic [7:0] CMC_ADDR_MODE = 8'h12;
	localparam logic [7:0] CMC_ADDR_GATE = 8'h13;

	// converter_mode_control bits
	localparam int CMC_B_KILL    = 7;
	localparam int CMC_B_REV_ON  = 6;
	localparam int CMC_B_REV_LL  = 5;
	localparam int CMC_B_FWD_LL  = 4;
	localparam int CMC_B_WAKE    = 3;
	localparam int CMC_B_PRE_LIN = 2;
	localparam int CMC_B_REV_OOA = 1;
	localparam int CMC_B_FWD_OOA = 0;

	// gate_drive_protection_control bits
	localparam int CMC_B_GATE2   = 7;
	localparam int CMC_B_GATE1   = 6;
	localparam int CMC_B_RATE    = 5;
	localparam int CMC_B_STAT    = 4;
	localparam int CMC_B_SHORT   = 3;
	localparam int CMC_B_UVP     = 2;
	localparam int CMC_B_FDET    = 1;
	localparam int CMC_B_OCP     = 0;

	localparam logic [7:0] CMC_MODE_RESET = 8'h00;
	// rate bit is overlaid with the captured strap level
	localparam logic [7:0] CMC_GATE_RESET = 8'h01;

	// bits that a watchdog expiry returns to zero
	localparam logic [7:0] CMC_MODE_WD_MASK = 8'h66;
	localparam logic [7:0] CMC_GATE_WD_MASK = 8'h10;

	// pin inputs are valid after the synchroniser fills
	localparam logic [1:0] CMC_CAPTURE_CYCLES = 2'h3;

	localparam int CMC_CLK_PERIOD_PS = 4000;
	localparam int CMC_SETTLE_NS     = 1000;
	localparam int CMC_SETTLE_CYCLES =
		(CMC_SETTLE_NS * 1000 + CMC_CLK_PERIOD_PS - 1) / CMC_CLK_PERIOD_PS;
	localparam logic [7:0] CMC_SETTLE_LAST = 8'(CMC_SETTLE_CYCLES - 1);

	typedef enum logic [1:0]
	{
		CMC_FD_IDLE = 2'h0,
		CMC_FD_HOLD = 2'h1,
		CMC_FD_MEAS = 2'h3,
		CMC_FD_PUBL = 2'h2
	} cmc_fd_state_t;

endpackage

//--- src/cmc_sync.sv
// Purpose: two-flop synchroniser, one lane per bit
// Assumes: inputs are quasi-static pin levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module cmc_sync
#(
	parameter int WIDTH = 4
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	generate
		if (WIDTH < 1)
		begin : g_bad
			$error("cmc_sync: WIDTH must be at least 1");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_lane
			logic stage1;
			always_ff @(posedge core_clk)
			begin
				if (!resetn)
				begin
					stage1      <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					stage1      <= async_in[i];
					sync_out[i] <= stage1;
				end
			end
		end
	endgenerate

endmodule // cmc_sync

//--- src/cmc_mode_regs.sv
// Purpose: converter mode and gate drive control registers
// Assumes: byte register port from the serial bus engine, same clock
// Notes:   forced limit detection runs a small hold/measure sequence
// What this block does
// - while the kill bit is set both input gate enables read and drive 0.
// - reverse output bit drives reverse mode, cleared by watchdog or reset.
// - reverse light-load disable bit, cleared by watchdog or reset.
// - forward light-load disable bit, cleared only by register reset.
// - precharge linear-mode disable bit, cleared by watchdog or reset.
// - reverse out-of-audio disable bit, cleared by watchdog or reset.
// - forward out-of-audio disable bit, cleared only by register reset.
// - gate two enable drives its driver and is locked at 0 if absent.
// - gate one enable drives its driver and is locked at 0 if absent.
// - rate select picks 1.5 MHz at 0, 750 kHz at 1, starts from strap.
// - status pin disable bit, cleared by watchdog or reset.
// - both hiccup disable bits are cleared only by register reset.
// - forced detection accepts a 1 only while battery exceeds minimum.
// - forced detection stops switching, measures, publishes, self-clears.
// - overcurrent enable defaults to 1 and returns there on reset.
`timescale 1ns/1ps
module cmc_mode_regs
#(
	parameter int ADC_W = 16
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	output logic                  reg_rvalid,
	input  wire logic             regs_reset,
	input  wire logic             watchdog_expired,
	input  wire logic             strap_pin,
	input  wire logic             gate_one_present,
	input  wire logic             gate_two_present,
	input  wire logic             vbat_above_min,
	output logic                  input_gate_kill,
	output logic                  reverse_output_on,
	output logic                  reverse_light_load_off,
	output logic                  forward_light_load_off,
	output logic                  wake_delay_sel,
	output logic                  precharge_linear_off,
	output logic                  reverse_out_of_audio_off,
	output logic                  forward_out_of_audio_off,
	output logic                  input_gate_two_on,
	output logic                  input_gate_one_on,
	output logic                  switching_rate_sel,
	output logic                  status_pin_off,
	output logic                  rail_short_hiccup_off,
	output logic                  reverse_undervolt_hiccup_off,
	output logic                  forced_input_limit_detect,
	output logic                  input_overcurrent_on,
	output logic                  converter_hold,
	output logic                  adc_req,
	input  wire logic             adc_done,
	input  wire logic [ADC_W-1:0] adc_result,
	output logic                  limit_wr,
	output logic      [ADC_W-1:0] limit_value
);

	generate
		if (ADC_W < 1 || ADC_W > 32)
		begin : g_bad
			$error("cmc_mode_regs: ADC_W must be 1 to 32");
		end
	endgenerate

	logic [3:0] pins_sync;
	logic       strap_s;
	logic       one_s;
	logic       two_s;
	logic       vbat_ok;

	cmc_sync #(.WIDTH(4)) u_sync
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.async_in ({vbat_above_min, gate_two_present,
		            gate_one_present, strap_pin}),
		.sync_out (pins_sync)
	);

	assign strap_s = pins_sync[0];
	assign one_s   = pins_sync[1];
	assign two_s   = pins_sync[2];
	assign vbat_ok = pins_sync[3];

	// power-on capture of strap and switch presence
	logic [1:0] cap_cnt;
	logic [1:0] next_cap_cnt;
	logic       captured;
	logic       next_captured;
	logic       strap_val;
	logic       next_strap_val;
	logic       one_ok;
	logic       next_one_ok;
	logic       two_ok;
	logic       next_two_ok;
	logic       cap_now;

	always_comb
	begin
		next_cap_cnt   = cap_cnt;
		next_captured  = captured;
		next_strap_val = strap_val;
		next_one_ok    = one_ok;
		next_two_ok    = two_ok;
		cap_now        = 1'b0;
		if (!captured)
		begin
			next_cap_cnt = cap_cnt + 2'h1;
			if (cap_cnt == cmc_pkg::CMC_CAPTURE_CYCLES)
			begin
				cap_now        = 1'b1;
				next_captured  = 1'b1;
				next_strap_val = strap_s;
				next_one_ok    = one_s;
				next_two_ok    = two_s;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			cap_cnt   <= 2'h0;
			captured  <= 1'b0;
			strap_val <= 1'b0;
			one_ok    <= 1'b0;
			two_ok    <= 1'b0;
		end
		else
		begin
			cap_cnt   <= next_cap_cnt;
			captured  <= next_captured;
			strap_val <= next_strap_val;
			one_ok    <= next_one_ok;
			two_ok    <= next_two_ok;
		end
	end

	// forced detection sequencer
	cmc_pkg::cmc_fd_state_t fd_state;
	cmc_pkg::cmc_fd_state_t next_fd_state;
	logic [7:0]             settle_cnt;
	logic [7:0]             next_settle_cnt;
	logic [ADC_W-1:0]       next_limit_value;
	logic [7:0]             mode_r;
	logic [7:0]             gate_r;
	logic [7:0]             next_mode;
	logic [7:0]             next_gate;

	always_comb
	begin
		next_fd_state    = fd_state;
		next_settle_cnt  = settle_cnt;
		next_limit_value = limit_value;
		case (fd_state)
			cmc_pkg::CMC_FD_IDLE:
			begin
				next_settle_cnt = 8'h00;
				if (gate_r[cmc_pkg::CMC_B_FDET])
					next_fd_state = cmc_pkg::CMC_FD_HOLD;
			end
			// input current falls to zero before sampling
			cmc_pkg::CMC_FD_HOLD:
			begin
				next_settle_cnt = settle_cnt + 8'h01;
				if (settle_cnt == cmc_pkg::CMC_SETTLE_LAST)
					next_fd_state = cmc_pkg::CMC_FD_MEAS;
			end
			cmc_pkg::CMC_FD_MEAS:
			begin
				if (adc_done)
				begin
					next_limit_value = adc_result;
					next_fd_state    = cmc_pkg::CMC_FD_PUBL;
				end
			end
			cmc_pkg::CMC_FD_PUBL:
				next_fd_state = cmc_pkg::CMC_FD_IDLE;
			default:
				next_fd_state = cmc_pkg::CMC_FD_IDLE;
		endcase
		if (regs_reset)
			next_fd_state = cmc_pkg::CMC_FD_IDLE;
	end

	assign converter_hold = (fd_state != cmc_pkg::CMC_FD_IDLE);
	assign adc_req        = (fd_state == cmc_pkg::CMC_FD_MEAS);
	assign limit_wr       = (fd_state == cmc_pkg::CMC_FD_PUBL);

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			fd_state    <= cmc_pkg::CMC_FD_IDLE;
			settle_cnt  <= 8'h00;
			limit_value <= '0;
		end
		else
		begin
			fd_state    <= next_fd_state;
			settle_cnt  <= next_settle_cnt;
			limit_value <= next_limit_value;
		end
	end

	// register pair
	logic wr_mode;
	logic wr_gate;

	assign wr_mode = reg_wr && (reg_addr == cmc_pkg::CMC_ADDR_MODE);
	assign wr_gate = reg_wr && (reg_addr == cmc_pkg::CMC_ADDR_GATE);

	always_comb
	begin
		next_mode = mode_r;
		next_gate = gate_r;
		// self-clear ahead of writes, so a new set wins
		if (limit_wr)
			next_gate[cmc_pkg::CMC_B_FDET] = 1'b0;
		if (wr_mode)
			next_mode = reg_wdata;
		if (wr_gate)
		begin
			next_gate[7:2] = reg_wdata[7:2];
			next_gate[cmc_pkg::CMC_B_OCP] = reg_wdata[cmc_pkg::CMC_B_OCP];
			// set only above minimum system voltage
			if (reg_wdata[cmc_pkg::CMC_B_FDET] && vbat_ok)
				next_gate[cmc_pkg::CMC_B_FDET] = 1'b1;
		end
		if (watchdog_expired)
		begin
			next_mode = next_mode & ~cmc_pkg::CMC_MODE_WD_MASK;
			next_gate = next_gate & ~cmc_pkg::CMC_GATE_WD_MASK;
		end
		if (regs_reset)
		begin
			next_mode = cmc_pkg::CMC_MODE_RESET;
			next_gate = cmc_pkg::CMC_GATE_RESET;
			next_gate[cmc_pkg::CMC_B_RATE] = strap_val;
		end
		if (cap_now)
			next_gate[cmc_pkg::CMC_B_RATE] = strap_s;
		// kill forces both gate enables low
		if (next_mode[cmc_pkg::CMC_B_KILL])
		begin
			next_gate[cmc_pkg::CMC_B_GATE1] = 1'b0;
			next_gate[cmc_pkg::CMC_B_GATE2] = 1'b0;
		end
		// absent switch pair locks its enable
		if (!next_two_ok)
			next_gate[cmc_pkg::CMC_B_GATE2] = 1'b0;
		// absent switch pair locks its enable
		if (!next_one_ok)
			next_gate[cmc_pkg::CMC_B_GATE1] = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			mode_r <= cmc_pkg::CMC_MODE_RESET;
			gate_r <= cmc_pkg::CMC_GATE_RESET;
		end
		else
		begin
			mode_r <= next_mode;
			gate_r <= next_gate;
		end
	end

	assign input_gate_kill              = mode_r[cmc_pkg::CMC_B_KILL];
	assign reverse_output_on            = mode_r[cmc_pkg::CMC_B_REV_ON];
	assign reverse_light_load_off       = mode_r[cmc_pkg::CMC_B_REV_LL];
	assign forward_light_load_off       = mode_r[cmc_pkg::CMC_B_FWD_LL];
	assign wake_delay_sel               = mode_r[cmc_pkg::CMC_B_WAKE];
	assign precharge_linear_off         = mode_r[cmc_pkg::CMC_B_PRE_LIN];
	assign reverse_out_of_audio_off     = mode_r[cmc_pkg::CMC_B_REV_OOA];
	assign forward_out_of_audio_off     = mode_r[cmc_pkg::CMC_B_FWD_OOA];
	assign input_gate_two_on            = gate_r[cmc_pkg::CMC_B_GATE2];
	assign input_gate_one_on            = gate_r[cmc_pkg::CMC_B_GATE1];
	assign switching_rate_sel           = gate_r[cmc_pkg::CMC_B_RATE];
	assign status_pin_off               = gate_r[cmc_pkg::CMC_B_STAT];
	assign rail_short_hiccup_off        = gate_r[cmc_pkg::CMC_B_SHORT];
	assign reverse_undervolt_hiccup_off = gate_r[cmc_pkg::CMC_B_UVP];
	assign forced_input_limit_detect    = gate_r[cmc_pkg::CMC_B_FDET];
	assign input_overcurrent_on         = gate_r[cmc_pkg::CMC_B_OCP];

	// read port, answer one cycle after the strobe
	logic [7:0] next_rdata;

	always_comb
	begin
		next_rdata = reg_rdata;
		if (reg_rd)
		begin
			case (reg_addr)
				cmc_pkg::CMC_ADDR_MODE: next_rdata = mode_r;
				cmc_pkg::CMC_ADDR_GATE: next_rdata = gate_r;
				default:                next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rdata  <= next_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence seq_measured;
		fd_state == cmc_pkg::CMC_FD_MEAS && adc_done && !regs_reset;
	endsequence

	sequence seq_published;
		limit_wr ##1 (fd_state == cmc_pkg::CMC_FD_IDLE);
	endsequence

	chk_kill_gates: assert property (
		input_gate_kill |-> !input_gate_one_on && !input_gate_two_on)
		else $error("gate enable high while kill set");

	chk_reverse_write: assert property (
		wr_mode && !regs_reset && !watchdog_expired
		|=> reverse_output_on == $past(reg_wdata[cmc_pkg::CMC_B_REV_ON]))
		else $error("reverse enable did not take written value");

	chk_wd_clears: assert property (
		watchdog_expired |=> !reverse_output_on && !reverse_light_load_off
		&& !precharge_linear_off && !reverse_out_of_audio_off
		&& !status_pin_off)
		else $error("watchdog left a bit set");

	chk_wd_keeps: assert property (
		watchdog_expired && !regs_reset && !reg_wr
		|=> $stable(forward_light_load_off) && $stable(wake_delay_sel)
		&& $stable(forward_out_of_audio_off) && $stable(input_overcurrent_on)
		&& $stable(rail_short_hiccup_off)
		&& $stable(reverse_undervolt_hiccup_off))
		else $error("watchdog changed a reset-only bit");

	chk_reset_defaults: assert property (
		regs_reset && captured |=> mode_r == 8'h00 && input_overcurrent_on
		&& switching_rate_sel == strap_val && !forced_input_limit_detect)
		else $error("register reset left wrong values");

	chk_gate_lock: assert property (
		(!one_ok |-> !input_gate_one_on) and (!two_ok |-> !input_gate_two_on))
		else $error("absent switch pair enabled");

	chk_fd_accept: assert property (
		wr_gate && reg_wdata[cmc_pkg::CMC_B_FDET] && !vbat_ok
		&& !forced_input_limit_detect |=> !forced_input_limit_detect)
		else $error("forced detection taken below minimum");

	chk_fd_publish: assert property (
		seq_measured |=> seq_published)
		else $error("measured value not published");

	chk_hold_meas: assert property (
		$rose(converter_hold) && !regs_reset |->
		!adc_req [*8] ##[1:300] adc_req && converter_hold)
		else $error("measurement not reached under hold");

	chk_strap_rate: assert property (
		cap_now && !regs_reset |=> switching_rate_sel == strap_val)
		else $error("rate select not loaded from strap");

endmodule // cmc_mode_regs

//--- dv/cmc_adc_model.sv
// Purpose: converter model that answers forced limit detection
// Assumes: request is a level held until the done pulse
// Notes:   result bus toggles outside the done cycle
`timescale 1ns/1ps
module cmc_adc_model
#(
	parameter int               ADC_W  = 16,
	parameter int               DELAY  = 5,
	parameter logic [ADC_W-1:0] RESULT = 16'h5A3C
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             adc_req,
	output logic                  adc_done,
	output logic      [ADC_W-1:0] adc_result
);
	int cnt;

	always @(posedge core_clk)
	begin
		adc_done <= 1'b0;
		adc_result <= ~adc_result;
		if (!resetn)
			adc_result <= RESULT;
		if (!resetn || !adc_req || adc_done)
			cnt <= 0;
		else if (cnt == DELAY)
		begin
			adc_done <= 1'b1;
			adc_result <= RESULT;
			cnt <= 0;
		end
		else
			cnt <= cnt + 1;
	end
endmodule // cmc_adc_model

//--- dv/charger_mode_control_regs_bench.sv
// Purpose: register tests for the charger mode control pair
// Assumes: strap and presence pins flip for a second power-on reset
// Notes:   inputs move on the falling edge only
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module charger_mode_control_regs_bench;
	logic        core_clk;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic        regs_reset = 1'b0;
	logic        watchdog_expired = 1'b0;
	logic        vbat_above_min = 1'b0;
	logic        strap_pin = 1'b1;
	logic        gate_one_present = 1'b1;
	logic        gate_two_present = 1'b0;
	logic [7:0]  mode_o;
	logic [7:0]  gate_o;
	logic        converter_hold;
	logic        adc_req;
	logic        adc_done;
	logic [15:0] adc_result;
	logic        limit_wr;
	logic [15:0] limit_value;
	int          errors = 0;
	int          n_compared = 0;
	int          k;

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	cmc_mode_regs #(.ADC_W(16)) dut
	(
		.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.regs_reset(regs_reset), .watchdog_expired(watchdog_expired),
		.strap_pin(strap_pin), .gate_one_present(gate_one_present),
		.gate_two_present(gate_two_present),
		.vbat_above_min(vbat_above_min),
		.input_gate_kill(mode_o[7]), .reverse_output_on(mode_o[6]),
		.reverse_light_load_off(mode_o[5]),
		.forward_light_load_off(mode_o[4]), .wake_delay_sel(mode_o[3]),
		.precharge_linear_off(mode_o[2]),
		.reverse_out_of_audio_off(mode_o[1]),
		.forward_out_of_audio_off(mode_o[0]),
		.input_gate_two_on(gate_o[7]), .input_gate_one_on(gate_o[6]),
		.switching_rate_sel(gate_o[5]), .status_pin_off(gate_o[4]),
		.rail_short_hiccup_off(gate_o[3]),
		.reverse_undervolt_hiccup_off(gate_o[2]),
		.forced_input_limit_detect(gate_o[1]),
		.input_overcurrent_on(gate_o[0]),
		.converter_hold(converter_hold), .adc_req(adc_req),
		.adc_done(adc_done), .adc_result(adc_result),
		.limit_wr(limit_wr), .limit_value(limit_value)
	);

	cmc_adc_model #(.ADC_W(16), .DELAY(5), .RESULT(16'h5A3C)) u_adc
	(
		.core_clk(core_clk), .resetn(resetn), .adc_req(adc_req),
		.adc_done(adc_done), .adc_result(adc_result)
	);

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic expire(input bit ok);
		if (!ok)
		begin
			errors++;
			$display("[ERR] wait expired exp 1 got 0");
			wrap_up();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		int i;
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
			@(negedge core_clk);
		expire(reg_rvalid === 1'b1);
		`CHK(nm, e, reg_rdata)
	endtask

	// one-cycle pulse: 0 watchdog, 1 register reset
	task automatic strobe(input bit which);
		@(negedge core_clk);
		if (which)
			regs_reset = 1'b1;
		else
			watchdog_expired = 1'b1;
		@(negedge core_clk);
		regs_reset = 1'b0;
		watchdog_expired = 1'b0;
	endtask

	initial
	begin
		repeat (10) @(negedge core_clk);
		resetn = 1'b1;
		// gate enable writes only stick once presence is captured
		repeat (6) @(negedge core_clk);
		rdchk(8'h12, 8'h00, "mode reset");
		rdchk(8'h13, 8'h21, "gate reset");
		`CHK("gate outs", 8'h21, gate_o)
		rdchk(8'h14, 8'h00, "unmapped");
		$display("test reset done");

		wr(8'h12, 8'h7F);
		`CHK("mode outs", 8'h7F, mode_o)
		rdchk(8'h12, 8'h7F, "mode rw");
		wr(8'h13, 8'hFD);
		`CHK("gate outs", 8'h7D, gate_o)
		rdchk(8'h13, 8'h7D, "gate rw");
		$display("test write done");

		wr(8'h12, 8'hFF);
		`CHK("gates killed", 2'b00, gate_o[7:6])
		rdchk(8'h13, 8'h3D, "kill read");
		wr(8'h13, 8'h7D);
		rdchk(8'h13, 8'h3D, "kill hold");
		wr(8'h12, 8'h7F);
		wr(8'h13, 8'h7D);
		rdchk(8'h13, 8'h7D, "kill off");
		$display("test kill done");

		strobe(1'b0);
		rdchk(8'h12, 8'h19, "mode wdog");
		rdchk(8'h13, 8'h6D, "gate wdog");
		$display("test watchdog done");

		wr(8'h13, 8'h4C);
		rdchk(8'h13, 8'h4C, "rate low");
		`CHK("rate out", 1'b0, gate_o[5])
		strobe(1'b1);
		rdchk(8'h12, 8'h00, "mode rreset");
		rdchk(8'h13, 8'h21, "gate rreset");
		$display("test register reset done");

		wr(8'h13, 8'h23);
		rdchk(8'h13, 8'h21, "fdet refused");
		@(negedge core_clk);
		vbat_above_min = 1'b1;
		// battery level passes a two-stage synchroniser
		repeat (4) @(negedge core_clk);
		wr(8'h13, 8'h23);
		`CHK("fdet set", 1'b1, gate_o[1])
		for (k = 0; k < 4 && converter_hold !== 1'b1; k++)
			@(negedge core_clk);
		expire(converter_hold === 1'b1);
		for (k = 0; k < 400 && adc_req !== 1'b1; k++)
			@(negedge core_clk);
		`CHK("hold cycles", 250, k)
		for (k = 0; k < 20 && limit_wr !== 1'b1; k++)
			@(negedge core_clk);
		expire(limit_wr === 1'b1);
		`CHK("limit value", 16'h5A3C, limit_value)
		`CHK("hold in publish", 1'b1, converter_hold)
		@(negedge core_clk);
		`CHK("hold released", 1'b0, converter_hold)
		`CHK("fdet cleared", 1'b0, gate_o[1])
		rdchk(8'h13, 8'h21, "fdet read");
		$display("test forced detection done");

		// second power-on with the other strap and the other pair fitted
		@(negedge core_clk);
		resetn = 1'b0;
		strap_pin = 1'b0;
		gate_one_present = 1'b0;
		gate_two_present = 1'b1;
		repeat (10) @(negedge core_clk);
		resetn = 1'b1;
		repeat (6) @(negedge core_clk);
		rdchk(8'h13, 8'h01, "strap low");
		wr(8'h13, 8'hC1);
		`CHK("pair swap outs", 8'h81, gate_o)
		rdchk(8'h13, 8'h81, "pair swap");
		wr(8'h12, 8'h80);
		rdchk(8'h13, 8'h01, "kill gate two");
		strobe(1'b1);
		rdchk(8'h13, 8'h01, "strap rreset");
		$display("test strap reset done");
		wrap_up();
	end

	initial
	begin
		#100000;
		errors++;
		$display("[ERR] run time exp done got hang");
		wrap_up();
	end
endmodule // charger_mode_control_regs_bench
